/* include/ssh_pkg.sv */
// Package with constants, types and register map of the setpoint select and burnout supervisor.
package ssh_pkg;
	localparam int          SSH_AW          = 8;
	localparam int          SSH_VW          = 16;
	// Register byte offsets.
	localparam logic [7:0]  SSH_REG_CTRL    = 8'h00;
	localparam logic [7:0]  SSH_REG_FIXSP   = 8'h04;
	localparam logic [7:0]  SSH_REG_SPLIM   = 8'h08;
	localparam logic [7:0]  SSH_REG_BOTH    = 8'h0C;
	localparam logic [7:0]  SSH_REG_OCTH    = 8'h10;
	localparam logic [7:0]  SSH_REG_ONTIME  = 8'h14;
	localparam logic [7:0]  SSH_REG_STATUS  = 8'h18;
	localparam logic [7:0]  SSH_REG_CURRENT = 8'h1C;
	localparam logic [7:0]  SSH_REG_ACTSP   = 8'h20;
	// Control register fields, and the bit position of the high limit in the setpoint limit register.
	localparam int          SSH_CTRL_MODE_LO = 0;
	localparam int          SSH_CTRL_BO_EN   = 2;
	localparam int          SSH_CTRL_OC_EN   = 3;
	localparam int          SSH_CTRL_ALM1    = 4;
	localparam int          SSH_LIM_HI_LSB   = 16;
	// Status register fields.
	localparam int          SSH_ST_BO        = 0;
	localparam int          SSH_ST_OC        = 1;
	localparam int          SSH_ST_OVF       = 2;
	localparam int          SSH_ST_MON       = 3;
	localparam int          SSH_ST_FIXREJ    = 4;
	// Values in tenths of an ampere.
	localparam logic [15:0] SSH_CUR_MAX      = 16'h0226;
	localparam logic [15:0] SSH_TH_MAX       = 16'h01F4;
	localparam logic [15:0] SSH_TH_ZERO      = 16'h0000;
	localparam logic [15:0] SSH_OVF_CODE     = 16'hFFFF;
	localparam logic [15:0] SSH_FIXSP_RST    = 16'h0000;
	localparam logic [15:0] SSH_OCTH_RST     = 16'h01F4;
	localparam logic [15:0] SSH_SPLO_RST     = 16'h0000;
	localparam logic [15:0] SSH_SPHI_RST     = 16'hFFFF;
	// ON time threshold in milliseconds, and flash period.
	localparam logic [15:0] SSH_ONTIME_MIN_MS = 16'h0064;
	localparam int          SSH_FLASH_BITS    = 24;
	localparam logic [31:0] SSH_RDATA_ZERO    = 32'h0000_0000;
	typedef enum logic [2:0] {
		SSH_MODE_PROGRAM = 3'b001,
		SSH_MODE_FIXED   = 3'b010,
		SSH_MODE_REMOTE  = 3'b100
	} ssh_mode_t;
	localparam logic [1:0]  SSH_CODE_PROGRAM = 2'h0;
	localparam logic [1:0]  SSH_CODE_FIXED   = 2'h1;
	localparam logic [1:0]  SSH_CODE_REMOTE  = 2'h2;
endpackage : ssh_pkg

/* include/ssh_cfg_if.sv */
// Interface carrying configuration and alarm results between the supervisor modules.
`timescale 1ns/100ps
`default_nettype none
interface ssh_cfg_if;
	import ssh_pkg::*;
	logic [15:0] current;     // Sampled current, tenths of an ampere.
	logic        sample;      // New sample strobe.
	logic        bo_enable;   // Burnout comparison allowed.
	logic        oc_enable;   // Overcurrent comparison allowed.
	logic [15:0] bo_thresh;   // Burnout threshold.
	logic [15:0] oc_thresh;   // Overcurrent threshold.
	logic        bo_alarm;    // Burnout alarm.
	logic        oc_alarm;    // Overcurrent alarm.
	logic        overflow;    // Reading above range.
	logic [15:0] shown;       // Reported current value.
	modport ctrl (output current, sample, bo_enable, oc_enable, bo_thresh, oc_thresh,
		input bo_alarm, oc_alarm, overflow, shown);
	modport mon (input current, sample, bo_enable, oc_enable, bo_thresh, oc_thresh,
		output bo_alarm, oc_alarm, overflow, shown);
endinterface : ssh_cfg_if
`default_nettype wire

/* hdl/ssh_sp_select.sv */
// Setpoint source multiplexer with registered active setpoint and indicator.
`timescale 1ns/100ps
`default_nettype none
module ssh_sp_select
	import ssh_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic         clk_sys,     // System clock.
	input  wire logic         reset_n,     // Synchronous reset, active low.
	input  wire logic         clk_en,      // Clock enable.
	input  wire ssh_mode_t    mode,        // Selected source.
	input  wire logic [W-1:0] program_sp,  // Program generator setpoint.
	input  wire logic [W-1:0] fixed_sp,    // Stored fixed setpoint.
	input  wire logic [W-1:0] remote_sp,   // External setpoint.
	output var  logic [W-1:0] active_sp,   // Active setpoint.
	output var  logic         remote_ind   // Remote setpoint indicator.
);
	logic [W-1:0] next_active_sp;
	logic         next_remote_ind;

	always_comb begin
		next_remote_ind = 1'b0;
		unique case (mode)
			SSH_MODE_PROGRAM: next_active_sp = program_sp;
			SSH_MODE_FIXED:   next_active_sp = fixed_sp;   // [RULE_03]
			SSH_MODE_REMOTE: begin
				next_active_sp  = remote_sp;               // [RULE_02]
				next_remote_ind = 1'b1;                    // [RULE_02]
			end
			default:          next_active_sp = program_sp;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			active_sp  <= '0;
			remote_ind <= 1'b0;
		end else if (clk_en) begin
			active_sp  <= next_active_sp;
			remote_ind <= next_remote_ind;
		end
	end
endmodule : ssh_sp_select
`default_nettype wire

/* hdl/ssh_burnout_mon.sv */
// Heater current monitor with burnout, overcurrent and overflow detection.
`timescale 1ns/100ps
`default_nettype none
module ssh_burnout_mon
	import ssh_pkg::*;
(
	input  wire logic clk_sys,  // System clock.
	input  wire logic reset_n,  // Synchronous reset, active low.
	input  wire logic clk_en,   // Clock enable.
	ssh_cfg_if.mon    cfg       // Samples, thresholds and results.
);
	logic        next_bo;
	logic        next_oc;
	logic        next_ovf;
	logic [15:0] next_shown;
	logic        bo_q;
	logic        oc_q;
	logic        ovf_q;
	logic [15:0] shown_q;

	always_comb begin
		next_bo    = bo_q;
		next_oc    = oc_q;
		next_ovf   = ovf_q;
		next_shown = shown_q;
		if (cfg.sample) begin                                        // [RULE_16]
			next_ovf   = (cfg.current > SSH_CUR_MAX);
			next_shown = next_ovf ? SSH_OVF_CODE : cfg.current;       // [RULE_05] [RULE_06]
			// Zero burnout threshold never alarms; full-scale burnout threshold alarms whenever burnout comparison is enabled.
			if (!cfg.bo_enable || cfg.bo_thresh == SSH_TH_ZERO)       // [RULE_09] [RULE_12]
				next_bo = 1'b0;
			else if (cfg.bo_thresh >= SSH_TH_MAX)                     // [RULE_13]
				next_bo = 1'b1;
			else
				next_bo = (cfg.current < cfg.bo_thresh);              // [RULE_11]
			if (!cfg.oc_enable || cfg.oc_thresh >= SSH_TH_MAX)
				next_oc = 1'b0;
			else
				next_oc = (cfg.current > cfg.oc_thresh);              // [RULE_15]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bo_q    <= 1'b0;
			oc_q    <= 1'b0;
			ovf_q   <= 1'b0;
			shown_q <= '0;
		end else if (clk_en) begin
			bo_q    <= next_bo;
			oc_q    <= next_oc;
			ovf_q   <= next_ovf;
			shown_q <= next_shown;
		end
	end

	assign cfg.bo_alarm = bo_q;
	assign cfg.oc_alarm = oc_q;
	assign cfg.overflow = ovf_q;
	assign cfg.shown    = shown_q;
endmodule : ssh_burnout_mon
`default_nettype wire

/* hdl/ssh_top.sv */
// Top level: AHB-Lite registers, setpoint source selection and heater burnout supervision.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE_01] Three setpoint sources; reset selects program.
// [RULE_02] Remote mode uses external setpoint, lights indicator.
// [RULE_03] Fixed mode uses stored value, default zero.
// [RULE_04] Fixed setpoint accepted only within limits.
// [RULE_05] Report heater current, 0.0 to 55.0 A.
// [RULE_06] Above range reads as FFFF.
// [RULE_07] ON time at most 100 ms suppresses detection.
// [RULE_08] Monitor needs function enable and alarm 1.
// [RULE_09] Burnout compare needs switch on, alarm 1.
// [RULE_10] Burnout threshold 0.0 to 50.0 A, default 0.
// [RULE_11] Burnout alarm when current below threshold.
// [RULE_12] Threshold 0.0 keeps burnout alarm off.
// [RULE_13] Threshold 50.0 keeps burnout alarm on.
// [RULE_14] Any alarm lights indicator, flashes current display.
// [RULE_15] Overcurrent alarm above threshold, default 50.0 A. The code never raises it while the threshold is 50.0 A.
// [RULE_16] Re-evaluate on each sample, next edge.
// [RULE_17] Currents in tenths of an ampere.
module ssh_top
	import ssh_pkg::*;
(
	input  wire logic        clk_sys,                    // System clock, 100 MHz.
	input  wire logic        reset_n,                    // Synchronous reset, active low.
	input  wire logic        clk_en,                     // Clock enable, freezes state when low.
	input  wire logic        hsel,                       // AHB slave select.
	input  wire logic [31:0] haddr,                      // AHB address.
	input  wire logic [1:0]  htrans,                     // AHB transfer type.
	input  wire logic        hwrite,                     // AHB write.
	input  wire logic [2:0]  hsize,                      // AHB size.
	input  wire logic [31:0] hwdata,                     // AHB write data.
	input  wire logic        hready,                     // AHB bus ready.
	output var  logic [31:0] hrdata,                     // AHB read data.
	output var  logic        hreadyout,                  // AHB slave ready.
	output var  logic        hresp,                      // AHB response, always OKAY.
	input  wire logic [15:0] current_sense_input,        // Current sample, tenths of an ampere.
	input  wire logic        current_sample_valid,       // Current sample strobe.
	input  wire logic [15:0] program_sp,                 // Program generator setpoint.
	input  wire logic [15:0] remote_sp,                  // External remote setpoint.
	output var  logic [15:0] active_setpoint,            // Active setpoint.
	output var  logic        remote_setpoint_indicator,  // Remote setpoint indicator.
	output var  logic        heater_alarm_indicator,     // Heater alarm indicator.
	output var  logic        current_display_blank,      // Current display flash phase, high blanks.
	output var  logic        burnout_alarm,              // Burnout alarm output.
	output var  logic        overcurrent_alarm           // Overcurrent alarm output.
);
	ssh_cfg_if cfg ();

	// Software state.
	logic [1:0]  mode_code;
	logic        burnout_function_switch;
	logic        oc_use;
	logic        alarm1_assigned;
	logic [15:0] stored_fixed_setpoint;
	logic [15:0] sp_lo;
	logic [15:0] sp_hi;
	logic [15:0] burnout_threshold_ch1;
	logic [15:0] oc_thresh;
	logic [15:0] on_time_ms;
	logic        fix_rej;
	logic [1:0]  next_mode_code;
	logic        next_bfs;
	logic        next_oc_use;
	logic        next_alarm1;
	logic [15:0] next_fixsp;
	logic [15:0] next_sp_lo;
	logic [15:0] next_sp_hi;
	logic [15:0] next_bo_th;
	logic [15:0] next_oc_th;
	logic [15:0] next_on_time;
	logic        next_fix_rej;

	// Bus state.
	logic        dp_write;
	logic        dp_read;
	logic [7:0]  dp_addr;
	logic [31:0] next_hrdata;
	logic        next_dp_write;
	logic        next_dp_read;
	logic [7:0]  next_dp_addr;

	// Outputs and flash counter.
	logic [SSH_FLASH_BITS-1:0] flash_cnt;
	logic [SSH_FLASH_BITS-1:0] next_flash_cnt;
	logic        next_ha_ind;
	logic        next_blank;

	ssh_mode_t   mode;
	logic        detect_ok;
	logic        monitor_on;
	logic        any_alarm;
	logic [15:0] sp_sel;
	logic        rind_sel;

	always_comb begin
		unique case (mode_code)
			SSH_CODE_FIXED:  mode = SSH_MODE_FIXED;
			SSH_CODE_REMOTE: mode = SSH_MODE_REMOTE;
			default:         mode = SSH_MODE_PROGRAM;
		endcase
	end

	assign detect_ok  = (on_time_ms > SSH_ONTIME_MIN_MS);                              // [RULE_07]
	assign monitor_on = (burnout_function_switch || oc_use) && alarm1_assigned;        // [RULE_08]
	assign any_alarm  = cfg.bo_alarm || cfg.oc_alarm;

	assign cfg.current   = current_sense_input;                                        // [RULE_17]
	assign cfg.sample    = current_sample_valid && monitor_on;                         // [RULE_08]
	assign cfg.bo_enable = burnout_function_switch && alarm1_assigned && detect_ok;    // [RULE_09] [RULE_07]
	assign cfg.oc_enable = oc_use && alarm1_assigned && detect_ok;                     // [RULE_07]
	assign cfg.bo_thresh = burnout_threshold_ch1;
	assign cfg.oc_thresh = oc_thresh;

	ssh_burnout_mon u_mon (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.cfg     (cfg.mon)
	);

	ssh_sp_select #(.W(SSH_VW)) u_sel (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.clk_en     (clk_en),
		.mode       (mode),
		.program_sp (program_sp),
		.fixed_sp   (stored_fixed_setpoint),
		.remote_sp  (remote_sp),
		.active_sp  (sp_sel),
		.remote_ind (rind_sel)
	);

	// The slave never stalls, so the data phase always completes in one cycle.
	always_comb begin
		next_dp_write = 1'b0;
		next_dp_read  = 1'b0;
		next_dp_addr  = dp_addr;
		if (hsel && hready && htrans[1]) begin
			next_dp_write = hwrite;
			next_dp_read  = !hwrite;
			next_dp_addr  = haddr[SSH_AW-1:0];
		end
	end

	always_comb begin
		next_mode_code = mode_code;
		next_bfs       = burnout_function_switch;
		next_oc_use    = oc_use;
		next_alarm1    = alarm1_assigned;
		next_fixsp     = stored_fixed_setpoint;
		next_sp_lo     = sp_lo;
		next_sp_hi     = sp_hi;
		next_bo_th     = burnout_threshold_ch1;
		next_oc_th     = oc_thresh;
		next_on_time   = on_time_ms;
		next_fix_rej   = fix_rej;
		if (dp_write) begin
			unique case (dp_addr)
				SSH_REG_CTRL: begin
					// An unused mode code is ignored so the selector stays legal.
					if (hwdata[SSH_CTRL_MODE_LO +: 2] != 2'h3)
						next_mode_code = hwdata[SSH_CTRL_MODE_LO +: 2];  // [RULE_01]
					next_bfs    = hwdata[SSH_CTRL_BO_EN];
					next_oc_use = hwdata[SSH_CTRL_OC_EN];
					next_alarm1 = hwdata[SSH_CTRL_ALM1];
				end
				SSH_REG_FIXSP: begin
					if (hwdata[15:0] >= sp_lo && hwdata[15:0] <= sp_hi) begin  // [RULE_04]
						next_fixsp   = hwdata[15:0];
						next_fix_rej = 1'b0;
					end else begin
						next_fix_rej = 1'b1;
					end
				end
				SSH_REG_SPLIM: begin
					next_sp_lo = hwdata[15:0];
					next_sp_hi = hwdata[SSH_LIM_HI_LSB +: 16];
				end
				SSH_REG_BOTH: if (hwdata[15:0] <= SSH_TH_MAX) next_bo_th = hwdata[15:0];  // [RULE_10]
				SSH_REG_OCTH: if (hwdata[15:0] <= SSH_TH_MAX) next_oc_th = hwdata[15:0];
				SSH_REG_ONTIME: next_on_time = hwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		next_hrdata = SSH_RDATA_ZERO;
		if (next_dp_read) begin
			unique case (next_dp_addr)
				SSH_REG_CTRL: begin
					next_hrdata[SSH_CTRL_MODE_LO +: 2] = mode_code;
					next_hrdata[SSH_CTRL_BO_EN]        = burnout_function_switch;
					next_hrdata[SSH_CTRL_OC_EN]        = oc_use;
					next_hrdata[SSH_CTRL_ALM1]         = alarm1_assigned;
				end
				SSH_REG_FIXSP:   next_hrdata[15:0] = stored_fixed_setpoint;
				SSH_REG_SPLIM:   next_hrdata = {sp_hi, sp_lo};
				SSH_REG_BOTH:    next_hrdata[15:0] = burnout_threshold_ch1;
				SSH_REG_OCTH:    next_hrdata[15:0] = oc_thresh;
				SSH_REG_ONTIME:  next_hrdata[15:0] = on_time_ms;
				SSH_REG_STATUS: begin
					next_hrdata[SSH_ST_BO]     = cfg.bo_alarm;
					next_hrdata[SSH_ST_OC]     = cfg.oc_alarm;
					next_hrdata[SSH_ST_OVF]    = cfg.overflow;
					next_hrdata[SSH_ST_MON]    = monitor_on;
					next_hrdata[SSH_ST_FIXREJ] = fix_rej;
				end
				SSH_REG_CURRENT: next_hrdata[15:0] = cfg.shown;  // [RULE_05] [RULE_06]
				SSH_REG_ACTSP:   next_hrdata[15:0] = sp_sel;
				default: ;
			endcase
		end
	end

	// Flash toggles at a slow rate only while an alarm stands.
	always_comb begin
		next_flash_cnt = any_alarm ? flash_cnt + 1'b1 : '0;
		next_ha_ind    = any_alarm;                                                    // [RULE_14]
		next_blank     = any_alarm && flash_cnt[SSH_FLASH_BITS-1];                     // [RULE_14]
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			mode_code               <= SSH_CODE_PROGRAM;  // [RULE_01]
			burnout_function_switch <= 1'b0;
			oc_use                  <= 1'b0;
			alarm1_assigned         <= 1'b0;
			stored_fixed_setpoint   <= SSH_FIXSP_RST;     // [RULE_03]
			sp_lo                   <= SSH_SPLO_RST;
			sp_hi                   <= SSH_SPHI_RST;
			burnout_threshold_ch1   <= SSH_TH_ZERO;       // [RULE_10]
			oc_thresh               <= SSH_OCTH_RST;      // [RULE_15]
			on_time_ms              <= '0;
			fix_rej                 <= 1'b0;
			dp_write                <= 1'b0;
			dp_read                 <= 1'b0;
			dp_addr                 <= '0;
			hrdata                  <= SSH_RDATA_ZERO;
			hreadyout               <= 1'b1;
			hresp                   <= 1'b0;
			flash_cnt               <= '0;
			heater_alarm_indicator  <= 1'b0;
			current_display_blank   <= 1'b0;
			burnout_alarm           <= 1'b0;
			overcurrent_alarm       <= 1'b0;
			active_setpoint         <= '0;
			remote_setpoint_indicator <= 1'b0;
		end else if (clk_en) begin
			mode_code               <= next_mode_code;
			burnout_function_switch <= next_bfs;
			oc_use                  <= next_oc_use;
			alarm1_assigned         <= next_alarm1;
			stored_fixed_setpoint   <= next_fixsp;
			sp_lo                   <= next_sp_lo;
			sp_hi                   <= next_sp_hi;
			burnout_threshold_ch1   <= next_bo_th;
			oc_thresh               <= next_oc_th;
			on_time_ms              <= next_on_time;
			fix_rej                 <= next_fix_rej;
			dp_write                <= next_dp_write;
			dp_read                 <= next_dp_read;
			dp_addr                 <= next_dp_addr;
			hrdata                  <= next_hrdata;
			hreadyout               <= 1'b1;
			hresp                   <= 1'b0;
			flash_cnt               <= next_flash_cnt;
			heater_alarm_indicator  <= next_ha_ind;
			current_display_blank   <= next_blank;
			burnout_alarm           <= cfg.bo_alarm;
			overcurrent_alarm       <= cfg.oc_alarm;
			active_setpoint         <= sp_sel;
			remote_setpoint_indicator <= rind_sel;
		end
	end
endmodule : ssh_top
`default_nettype wire

/* test/ssh_top_checker.sv */
// Concurrent checks on the ports of the setpoint select and burnout supervisor.
`timescale 1ns/100ps
`default_nettype none
module ssh_top_checker
	import ssh_pkg::*;
(
	input wire logic        clk_sys,                    // System clock.
	input wire logic        reset_n,                    // Synchronous reset, active low.
	input wire logic        hsel,                       // AHB select.
	input wire logic [1:0]  htrans,                     // AHB transfer type.
	input wire logic        hwrite,                     // AHB write.
	input wire logic        hready,                     // AHB bus ready.
	input wire logic [31:0] hrdata,                     // AHB read data.
	input wire logic        hreadyout,                  // AHB slave ready.
	input wire logic        hresp,                      // AHB response.
	input wire logic [15:0] current_sense_input,        // Current sample.
	input wire logic        current_sample_valid,       // Sample strobe.
	input wire logic [15:0] remote_sp,                  // Remote setpoint.
	input wire logic [15:0] active_setpoint,            // Active setpoint.
	input wire logic        remote_setpoint_indicator,  // Remote indicator.
	input wire logic        heater_alarm_indicator,     // Heater alarm indicator.
	input wire logic        current_display_blank,      // Display flash phase.
	input wire logic        burnout_alarm,              // Burnout alarm.
	input wire logic        overcurrent_alarm           // Overcurrent alarm.
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_HRESP_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus response not OKAY or not ready");
	AST_HRDATA_IDLE: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0000_0000)
		else $error("read data not cleared outside a read");
	AST_RESET_OUT: assert property ($past(!reset_n) |-> !burnout_alarm && !overcurrent_alarm
		&& !remote_setpoint_indicator && active_setpoint == 16'h0000) else $error("outputs not cleared by reset");
	AST_REMOTE_SP: assert property (remote_setpoint_indicator && $past(remote_setpoint_indicator, 2)
		&& $stable(remote_sp) && $past(remote_sp) == $past(remote_sp, 2) |-> active_setpoint == remote_sp)
		else $error("remote setpoint not passed on");
	AST_HA_IND: assert property (heater_alarm_indicator == (burnout_alarm || overcurrent_alarm))
		else $error("heater alarm indicator disagrees with alarms");
	AST_BLANK_OFF: assert property (!heater_alarm_indicator && $past(!heater_alarm_indicator)
		|-> !current_display_blank) else $error("display flashes without alarm");
	AST_BO_RISE: assert property ($rose(burnout_alarm) |-> $past(current_sample_valid, 2))
		else $error("burnout alarm rose without a sample");
	AST_OC_RISE: assert property ($rose(overcurrent_alarm) |-> $past(current_sample_valid, 2)
		&& $past(current_sense_input, 2) != 16'h0000) else $error("overcurrent alarm rose without cause");
endmodule : ssh_top_checker
`default_nettype wire

/* test/ssh_ct_model.sv */
// Behavioural model of the current transformer measurement path feeding samples.
`timescale 1ns/100ps
`default_nettype none
module ssh_ct_model (
	input  wire logic        clk_sys,               // System clock.
	output var  logic [15:0] current_sense_input,   // Sampled current, tenths of an ampere.
	output var  logic        current_sample_valid   // One-cycle sample strobe.
);
	initial begin
		current_sense_input = 16'h0000;
		current_sample_valid = 1'b0;
	end
	// Call just after a rising edge; the value is only meaningful while the strobe stands.
	task automatic send(input logic [15:0] v);
		current_sense_input <= v;
		current_sample_valid <= 1'b1;
		@(posedge clk_sys);
		current_sample_valid <= 1'b0;
		current_sense_input <= ~v;
	endtask : send
endmodule : ssh_ct_model
`default_nettype wire

/* test/test_setpoint_select_heater_burnout_alarm.sv */
// Self-checking testbench of the setpoint select and heater burnout supervisor.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_setpoint_select_heater_burnout_alarm;
	import ssh_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [15:0] prog_sp = 16'h1234;
	logic [15:0] rem_sp = 16'h5678;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] cur;
	logic        vld;
	logic [15:0] act_sp;
	logic        rind;
	logic        hind;
	logic        blank;
	logic        bo;
	logic        oc;
	int          mismatches = 0;
	int          n_compared = 0;
	always #5 clk_sys = ~clk_sys;
	ssh_top ssh_top_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .current_sense_input(cur), .current_sample_valid(vld),
		.program_sp(prog_sp), .remote_sp(rem_sp), .active_setpoint(act_sp), .remote_setpoint_indicator(rind),
		.heater_alarm_indicator(hind), .current_display_blank(blank), .burnout_alarm(bo), .overcurrent_alarm(oc));
	ssh_ct_model ssh_ct_model_inst (.clk_sys(clk_sys), .current_sense_input(cur), .current_sample_valid(vld));
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// Values are taken at the falling edge, which is what the next rising edge samples.
	task automatic wait_ready(output logic [31:0] d);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		while (!ok && n < 100) begin
			@(negedge clk_sys);
			ok = (hreadyout === 1'b1);
			d = hrdata;
			@(posedge clk_sys);
			n++;
		end
		if (!ok) begin
			mismatches++;
			$display("mismatch hreadyout expected 1 seen timeout");
		end
	endtask : wait_ready
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		wait_ready(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(rd);
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		ahb(1'b1, a, wd, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0000_0000, d);
		`CHK(nm, d, exp)
	endtask : rd_chk
	task automatic sp_chk(input logic [15:0] esp, input logic eind);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("active_setpoint", act_sp, esp)
		`CHK("remote_setpoint_indicator", rind, eind)
		@(posedge clk_sys);
	endtask : sp_chk
	task automatic alarms(input logic [15:0] v, input logic ebo, input logic eoc);
		ssh_ct_model_inst.send(v);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("burnout_alarm", bo, ebo)
		`CHK("overcurrent_alarm", oc, eoc)
		`CHK("heater_alarm_indicator", hind, ebo | eoc)
		`CHK("current_display_blank", blank, 1'b0)
		@(posedge clk_sys);
	endtask : alarms
	task automatic t_reset;
		rd_chk(SSH_REG_CTRL, 32'h0000_0000, "ctrl");
		rd_chk(SSH_REG_FIXSP, 32'h0000_0000, "fixsp");
		rd_chk(SSH_REG_BOTH, 32'h0000_0000, "both");
		rd_chk(SSH_REG_OCTH, 32'h0000_01F4, "octh");
		rd_chk(8'h40, 32'h0000_0000, "unmapped");
		sp_chk(prog_sp, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_modes;
		wr(SSH_REG_CTRL, 32'h0000_0001);
		sp_chk(16'h0000, 1'b0);
		wr(SSH_REG_CTRL, 32'h0000_0002);
		sp_chk(rem_sp, 1'b1);
		wr(SSH_REG_CTRL, 32'h0000_0003);
		rem_sp <= 16'h9ABC;
		sp_chk(16'h9ABC, 1'b1);
		wr(SSH_REG_CTRL, 32'h0000_0000);
		sp_chk(prog_sp, 1'b0);
		clk_en <= 1'b0;
		wr(SSH_REG_CTRL, 32'h0000_0002);
		clk_en <= 1'b1;
		sp_chk(prog_sp, 1'b0);
		$display("mode test done");
	endtask : t_modes
	task automatic t_fixsp;
		wr(SSH_REG_SPLIM, 32'h0200_0100);
		wr(SSH_REG_FIXSP, 32'h0000_0200);
		wr(SSH_REG_FIXSP, 32'h0000_0201);
		rd_chk(SSH_REG_FIXSP, 32'h0000_0200, "fixsp high");
		rd_chk(SSH_REG_STATUS, 32'h0000_0010, "status reject");
		wr(SSH_REG_FIXSP, 32'h0000_00FF);
		rd_chk(SSH_REG_FIXSP, 32'h0000_0200, "fixsp low");
		wr(SSH_REG_FIXSP, 32'h0000_0100);
		wr(SSH_REG_CTRL, 32'h0000_0001);
		sp_chk(16'h0100, 1'b0);
		$display("fixed setpoint test done");
	endtask : t_fixsp
	task automatic t_burnout;
		wr(SSH_REG_ONTIME, 32'h0000_0065);
		wr(SSH_REG_BOTH, 32'h0000_0014);
		wr(SSH_REG_CTRL, 32'h0000_0014);
		alarms(16'h000A, 1'b1, 1'b0);
		rd_chk(SSH_REG_STATUS, 32'h0000_0009, "status burnout");
		alarms(16'h0014, 1'b0, 1'b0);
		alarms(16'h0013, 1'b1, 1'b0);
		wr(SSH_REG_BOTH, 32'h0000_0000);
		alarms(16'h0000, 1'b0, 1'b0);
		wr(SSH_REG_BOTH, 32'h0000_01F4);
		alarms(16'h0226, 1'b1, 1'b0);
		wr(SSH_REG_BOTH, 32'h0000_01F5);
		rd_chk(SSH_REG_BOTH, 32'h0000_01F4, "both limit");
		wr(SSH_REG_ONTIME, 32'h0000_0064);
		alarms(16'h0226, 1'b0, 1'b0);
		wr(SSH_REG_ONTIME, 32'h0000_0065);
		wr(SSH_REG_CTRL, 32'h0000_0004);
		alarms(16'h0226, 1'b0, 1'b0);
		rd_chk(SSH_REG_STATUS, 32'h0000_0000, "status off");
		$display("burnout test done");
	endtask : t_burnout
	task automatic t_current;
		wr(SSH_REG_CTRL, 32'h0000_0018);
		alarms(16'h0226, 1'b0, 1'b0);
		rd_chk(SSH_REG_CURRENT, 32'h0000_0226, "current max");
		alarms(16'h0227, 1'b0, 1'b0);
		rd_chk(SSH_REG_CURRENT, 32'h0000_FFFF, "current ovf");
		rd_chk(SSH_REG_STATUS, 32'h0000_000C, "status ovf");
		wr(SSH_REG_OCTH, 32'h0000_0064);
		alarms(16'h0064, 1'b0, 1'b0);
		alarms(16'h0065, 1'b0, 1'b1);
		alarms(16'h0000, 1'b0, 1'b0);
		$display("current test done");
	endtask : t_current
	initial begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_modes();
		t_fixsp();
		t_burnout();
		t_current();
		wrap_up();
	end
	initial begin
		#200000;
		mismatches++;
		$display("mismatch watchdog expected done seen timeout");
		wrap_up();
	end
endmodule : test_setpoint_select_heater_burnout_alarm
bind ssh_top ssh_top_checker ssh_top_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.current_sense_input(current_sense_input), .current_sample_valid(current_sample_valid),
	.remote_sp(remote_sp), .active_setpoint(active_setpoint), .remote_setpoint_indicator(remote_setpoint_indicator),
	.heater_alarm_indicator(heater_alarm_indicator), .current_display_blank(current_display_blank),
	.burnout_alarm(burnout_alarm), .overcurrent_alarm(overcurrent_alarm));
`default_nettype wire
